/* File: shared/ale_pkg.sv */
// Shared types and constants for the adaptive logic element.
// Assumes a 32-bit classic Wishbone register bus and one system clock.

package ale_pkg;

	// ---------------------------------------------------------------
	// Register offsets and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00; // Mode, packing, clocks, clears.
	localparam logic [7:0] MASK0_LO_OFS = 8'h04; // Table 0 truth bits 31..0.
	localparam logic [7:0] MASK0_HI_OFS = 8'h08; // Table 0 truth bits 63..32.
	localparam logic [7:0] MASK1_LO_OFS = 8'h0C; // Table 1 truth bits 31..0.
	localparam logic [7:0] MASK1_HI_OFS = 8'h10; // Table 1 truth bits 63..32.
	localparam logic [7:0] STATUS_OFS = 8'h14; // Read-only live state.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000; // Normal mode, no packing.
	localparam logic [31:0] MASK_RST = 32'h0000_0000; // Tables read zero.

	// ---------------------------------------------------------------
	// Carry chain start positions inside a cluster, counted from 0
	// ---------------------------------------------------------------
	localparam int CHAIN_START_FIRST = 0;
	localparam int CHAIN_START_SIXTH = 5;

	// ---------------------------------------------------------------
	// Enumerations
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_EXTENDED = 2'b01,
		MODE_ARITH = 2'b10
	} mode_t;

	typedef enum logic [1:0] {
		PACK_NONE = 2'b00,
		PACK_5LUT_1 = 2'b01,
		PACK_5LUT_2 = 2'b10,
		PACK_3LUT_2 = 2'b11
	} pack_t;

	typedef enum logic [1:0] {
		TIMING_NORMAL = 2'b00,
		TIMING_BORROW = 2'b01,
		TIMING_LATCH = 2'b10
	} timing_t;

	// ---------------------------------------------------------------
	// Register layouts, most significant field first
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] spare; // Reads as written, no effect.
		logic [1:0] aclr_sel; // Per pair: which cluster async clear.
		logic [1:0] sclr_sel; // Per pair: which cluster sync clear.
		logic [1:0] aclr_en; // Per pair: async clear used.
		logic [1:0] sclr_en; // Per pair: sync clear used.
		logic [1:0] ce_en; // Per pair: clock enable used.
		logic [7:0] clk_sel; // Per register: {delayed, source}.
		timing_t timing; // Register timing mode.
		logic carry_start; // Chain begins in this element.
		logic subtract; // Add or subtract.
		logic single6; // One six-input function.
		pack_t pack; // Packed register paths.
		mode_t mode; // Operating mode.
	} ctrl_t;

	typedef struct packed {
		logic [23:0] spare; // Reads zero.
		logic cfg_err; // Illegal configuration seen.
		logic carry_out; // Final carry of this element.
		logic [1:0] comb; // Combinational outputs.
		logic [3:0] regs; // Register outputs.
	} status_t;

	// ---------------------------------------------------------------
	// Carriers from the cluster local interconnect and control block
	// ---------------------------------------------------------------
	typedef struct packed {
		logic shared_a;
		logic shared_b;
		logic table0_in_c;
		logic table1_in_c;
		logic table0_in_d;
		logic table1_in_d;
		logic in_e;
		logic in_f;
	} elem_in_t;

	typedef struct packed {
		logic [1:0] cluster_clock; // Two cluster clock levels.
		logic [1:0] clk_en; // Two cluster clock enables.
		logic [1:0] sclr; // Two cluster sync clears.
		logic [1:0] aclr; // Two cluster async clears.
		logic cnt_en; // Counter enable, arithmetic mode.
		logic count_down; // Up or down direction.
	} cluster_ctrl_t;

endpackage

/* File: src/element_table.sv */
// One half-table: a 64-bit truth table read four ways.
// Assumes the index is already ordered by the caller for the mode.
`timescale 1ns/1ps

module element_table
	import ale_pkg::*;
(
	input wire logic [63:0] i_mask,
	input wire logic [5:0] i_idx,
	output logic o_out6,
	output logic o_out5,
	output logic o_quad0,
	output logic o_quad1
);

	// Full six-input read, low five-input read, two four-input reads.
	assign o_out6 = i_mask[i_idx];
	assign o_out5 = i_mask[{1'b0, i_idx[4:0]}];
	assign o_quad0 = i_mask[{2'b00, i_idx[3:0]}];
	assign o_quad1 = i_mask[{2'b01, i_idx[3:0]}];

endmodule

/* File: src/element_register.sv */
// One programmable element register emulated on the system clock.
// Assumes cluster clock levels are synchronous samples on i_clk.
`timescale 1ns/1ps

module element_register
	import ale_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire timing_t i_timing,
	input wire logic i_clk_norm,
	input wire logic i_clk_dly,
	input wire logic i_ce,
	input wire logic i_sclr,
	input wire logic i_d,
	output logic o_q
);

	logic prev_q, prev_d; // Last level of the normal clock.
	logic master_q, master_d; // Master latch.
	logic slave_q, slave_d; // Slave latch, drives the output.
	logic hold_q, hold_d; // Extra slave in the enable feedback.
	logic load; // Value offered to the master.

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// Enable is checked before clear, so a clear waits for the enable.
	always_comb
	begin
		prev_d = i_clk_norm;
		master_d = master_q;
		slave_d = slave_q;
		hold_d = hold_q;
		load = i_ce ? (i_d & ~i_sclr) : slave_q; // R24
		unique case (i_timing)
			TIMING_BORROW:
			begin
				// Feedback comes from the held copy, not the moving output.
				load = i_ce ? (i_d & ~i_sclr) : hold_q; // R20
				if (!i_clk_dly)
					master_d = load; // R19
				if (i_clk_norm)
					slave_d = master_q; // R19
				if (i_clk_dly)
					hold_d = slave_q; // R20
			end
			TIMING_LATCH:
			begin
				// Negative master latch, slave always transparent.
				if (!i_clk_dly)
					master_d = load; // R22
				slave_d = master_d; // R22
			end
			default:
			begin
				// Edge-triggered flip-flop on the selected clock.
				master_d = load;
				if (i_clk_norm && !prev_q)
					slave_d = load; // R27
			end
		endcase
	end

	// Register stage; the async clear brings every latch to zero.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			prev_q <= 1'b0;
			master_q <= 1'b0;
			slave_q <= 1'b0;
			hold_q <= 1'b0;
		end
		else
		begin
			prev_q <= prev_d;
			master_q <= master_d;
			slave_q <= slave_d;
			hold_q <= hold_d;
		end
	end

	assign o_q = slave_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	chk_capture_edge: assert property ( // R27
		(i_timing == TIMING_NORMAL && i_clk_norm && !prev_q && i_ce && !i_sclr)
		|=> (o_q == $past(i_d)))
		else $error("Register missed a capture on its clock edge.");

	chk_enable_first: assert property ( // R24
		(i_timing == TIMING_NORMAL && !i_ce) |=> $stable(o_q))
		else $error("Register changed with its enable low.");

	chk_sync_clear: assert property ( // R24
		(i_timing == TIMING_NORMAL && i_clk_norm && !prev_q && i_ce && i_sclr)
		|=> !o_q)
		else $error("Sync clear did not clear the register.");

	chk_latch_open: assert property ( // R22
		(i_timing == TIMING_LATCH && !i_clk_dly && i_ce && !i_sclr)
		|=> (o_q == $past(i_d)))
		else $error("Open latch did not pass its data.");

	cov_latch: cover property (i_timing == TIMING_LATCH && !i_clk_dly && i_ce);

endmodule

/* File: src/adaptive_logic_element.sv */
// Adaptive logic element: two half-tables, two adders, four registers.
// Assumes a classic Wishbone master and cluster signals synchronous to i_clk.
//
// Behaviour
// [R1] Normal mode: two functions or one six-input.
// [R2] Normal mode takes up to eight data inputs.
// [R3] Two five-input functions share inputs a, b.
// [R4] Four with five input pairing shares a or b.
// [R5] Smaller function pairs fit by table content.
// [R6] Inputs e,d0,c0,c1,d1,f; a,b feed both tables.
// [R7] Packing routes a and/or b straight to registers.
// [R8] Packing: 5-table one path, two paths, 3-tables.
// [R9] Six-input function disables register packing.
// [R10] Extended mode: eight-input function on all inputs.
// [R11] Extended packing only via shared a or b.
// [R12] Arithmetic: four-input table pairs feed two adders.
// [R13] Arithmetic: enables, up/down, add/sub, sync clear.
// [R14] Clear and enable per register pair switchable.
// [R15] Two-bit carry-select splits chain delay.
// [R16] Chain starts at first or sixth element only.
// [R17] Four cluster clocks selectable for each register.
// [R18] Two normal clocks plus two delayed copies.
// [R19] Borrowing: delayed clock master, normal clock slave.
// [R20] Borrowing: feedback slave holds previous data.
// [R21] Latch mode: one master, one slave clock.
// [R22] Latch: slave clock one high, master negative.
// [R23] Four registers with clocks, enable and clears.
// [R24] Clock enable takes priority over sync clear.
// [R25] Clears: two sync, two async, three total.
// [R26] Configuration is static while running.
// [R27] Normal register captures on selected clock edge.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module adaptive_logic_element
	import ale_pkg::*;
#(
	parameter int ELEMENT_POS = 0
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_run,
	input wire elem_in_t i_data,
	input wire cluster_ctrl_t i_cluster,
	input wire logic i_carry_in,
	output logic o_carry_out,
	output logic [1:0] o_comb,
	output logic [3:0] o_reg
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	ctrl_t ctrl_q, ctrl_d; // Configuration word.
	logic [31:0] mask_q [4]; // Truth table words.
	logic [31:0] mask_d [4];
	logic ack_q, ack_d; // Bus acknowledge.
	logic [31:0] rdat_q, rdat_d; // Read data held with ack.
	logic [1:0] dly_q, dly_d; // Delayed cluster clocks.
	logic wr; // Write takes effect this edge.
	status_t status; // Live status word.
	logic [5:0] idx0, idx1; // Table indices.
	logic t0_6, t0_5, t0_q0, t0_q1; // Table 0 reads.
	logic t1_6, t1_5, t1_q0, t1_q1; // Table 1 reads.
	logic sub_eff, y0, y1, cin; // Adder operands.
	logic p0, g0, p1, g1, c_mid, co0, co1, carry; // Carry select.
	logic pos_ok; // Element may start a chain.
	pack_t pack_eff; // Packing actually applied.
	logic [3:0] reg_data; // Data into each register.
	logic [1:0] sclr_used, aclr_used; // Distinct clears in use.
	logic [2:0] clears; // Count of distinct clears.
	logic cfg_err; // Illegal configuration.

	// Byte-lane merge for a write with select bits.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] new_val, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[8*i +: 8] = new_val[8*i +: 8];
		end
		return res;
	endfunction

	// ---------------------------------------------------------------
	// Wishbone slave
	// ---------------------------------------------------------------
	// Ack one cycle after the request; the write lands on the edge
	// where the master sees ack, so address and data are still held.
	// Writes while running are acked but dropped, keeping setup static.
	always_comb
	begin
		ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
		wr = i_wb_cyc & i_wb_stb & i_wb_we & ack_q & ~i_run; // R26
		rdat_d = rdat_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		if (ack_d)
		begin
			unique case (i_wb_adr)
				CTRL_OFS: rdat_d = ctrl_q;
				MASK0_LO_OFS: rdat_d = mask_q[0];
				MASK0_HI_OFS: rdat_d = mask_q[1];
				MASK1_LO_OFS: rdat_d = mask_q[2];
				MASK1_HI_OFS: rdat_d = mask_q[3];
				STATUS_OFS: rdat_d = status;
				default: rdat_d = 32'h0000_0000;
			endcase
		end
		if (wr)
		begin
			unique case (i_wb_adr)
				CTRL_OFS: ctrl_d = merge(ctrl_q, i_wb_dat, i_wb_sel);
				MASK0_LO_OFS: mask_d[0] = merge(mask_q[0], i_wb_dat, i_wb_sel);
				MASK0_HI_OFS: mask_d[1] = merge(mask_q[1], i_wb_dat, i_wb_sel);
				MASK1_LO_OFS: mask_d[2] = merge(mask_q[2], i_wb_dat, i_wb_sel);
				MASK1_HI_OFS: mask_d[3] = merge(mask_q[3], i_wb_dat, i_wb_sel);
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	// Bus and configuration registers.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
			for (int i = 0; i < 4; i++)
				mask_q[i] <= MASK_RST;
		end
		else
		begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

	// ---------------------------------------------------------------
	// Delay cell
	// ---------------------------------------------------------------
	// One system cycle of delay stands in for the analog delay cell.
	always_comb
	begin
		dly_d = i_cluster.cluster_clock; // R18
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			dly_q <= 2'b00;
		else
			dly_q <= dly_d;
	end

	// ---------------------------------------------------------------
	// Half-tables
	// ---------------------------------------------------------------
	// Shared a and b sit in the low bits of both indices.
	assign idx0 = {i_data.in_f, i_data.in_e, i_data.table0_in_d,
		i_data.table0_in_c, i_data.shared_b, i_data.shared_a}; // R6
	assign idx1 = {i_data.in_e, i_data.in_f, i_data.table1_in_d,
		i_data.table1_in_c, i_data.shared_b, i_data.shared_a}; // R6

	element_table u_table0 (
		.i_mask({mask_q[1], mask_q[0]}),
		.i_idx(idx0),
		.o_out6(t0_6),
		.o_out5(t0_5),
		.o_quad0(t0_q0),
		.o_quad1(t0_q1)
	);

	element_table u_table1 (
		.i_mask({mask_q[3], mask_q[2]}),
		.i_idx(idx1),
		.o_out6(t1_6),
		.o_out5(t1_5),
		.o_quad0(t1_q0),
		.o_quad1(t1_q1)
	);

	// ---------------------------------------------------------------
	// Adders and carry select
	// ---------------------------------------------------------------
	// Both carries of the two-bit block are formed ahead of the
	// incoming carry, which then only steers a mux.
	always_comb
	begin
		pos_ok = (ELEMENT_POS == CHAIN_START_FIRST) ||
			(ELEMENT_POS == CHAIN_START_SIXTH); // R16
		sub_eff = ctrl_q.subtract ^ i_cluster.count_down; // R13
		y0 = t0_q1 ^ sub_eff; // R12
		y1 = t1_q1 ^ sub_eff; // R12
		cin = (ctrl_q.carry_start && pos_ok) ? sub_eff : i_carry_in; // R16
		p0 = t0_q0 ^ y0;
		g0 = t0_q0 & y0;
		p1 = t1_q0 ^ y1;
		g1 = t1_q0 & y1;
		c_mid = g0 | (p0 & cin);
		co0 = g1 | (p1 & g0); // R15
		co1 = g1 | (p1 & (g0 | p0)); // R15
		carry = cin ? co1 : co0; // R15
	end

	// ---------------------------------------------------------------
	// Mode output select
	// ---------------------------------------------------------------
	always_comb
	begin
		o_carry_out = 1'b0;
		unique case (ctrl_q.mode)
			MODE_EXTENDED:
				// Table 1 picks between a six-input read and its own.
				o_comb = {t1_q0, t1_q0 ? t0_6 : t1_q1}; // R10
			MODE_ARITH:
			begin
				o_comb = {p1 ^ c_mid, p0 ^ cin}; // R12
				o_carry_out = carry; // R16
			end
			default:
				o_comb = ctrl_q.single6 ? {t0_6, t0_6} : {t1_5, t0_5}; // R1 R2 R3 R4 R5
		endcase
	end

	// ---------------------------------------------------------------
	// Register data and configuration checks
	// ---------------------------------------------------------------
	always_comb
	begin
		pack_eff = ctrl_q.pack;
		if (ctrl_q.mode == MODE_ARITH || (ctrl_q.mode != MODE_EXTENDED && ctrl_q.single6))
			pack_eff = PACK_NONE; // R9
		else if (ctrl_q.mode == MODE_EXTENDED && ctrl_q.pack == PACK_3LUT_2)
			pack_eff = PACK_5LUT_1; // R11
		reg_data[0] = o_comb[0];
		reg_data[2] = o_comb[1];
		reg_data[1] = (pack_eff != PACK_NONE) ? i_data.shared_a : o_comb[0]; // R7 R8
		reg_data[3] = (pack_eff == PACK_5LUT_2 || pack_eff == PACK_3LUT_2) ?
			i_data.shared_b : o_comb[1]; // R7 R8 R11
		for (int k = 0; k < 2; k++)
		begin
			sclr_used[k] = (ctrl_q.sclr_en[0] && ctrl_q.sclr_sel[0] == k[0]) ||
				(ctrl_q.sclr_en[1] && ctrl_q.sclr_sel[1] == k[0]);
			aclr_used[k] = (ctrl_q.aclr_en[0] && ctrl_q.aclr_sel[0] == k[0]) ||
				(ctrl_q.aclr_en[1] && ctrl_q.aclr_sel[1] == k[0]);
		end
		clears = 3'(sclr_used[0]) + 3'(sclr_used[1]) + 3'(aclr_used[0]) +
			3'(aclr_used[1]);
		cfg_err = (ctrl_q.mode == 2'b11) || (ctrl_q.timing == 2'b11) ||
			(clears > 3'd3) || // R25
			(ctrl_q.carry_start && !pos_ok) || (pack_eff != ctrl_q.pack); // R9 R16
	end

	assign status = '{spare: 24'h00_0000, cfg_err: cfg_err, carry_out: o_carry_out,
		comb: o_comb, regs: o_reg};

	// ---------------------------------------------------------------
	// Four registers, two per half-table pair
	// ---------------------------------------------------------------
	// The async clear is combined with system reset; clear inputs must
	// be glitch-free, as in the cluster control block.
	for (genvar g = 0; g < 4; g++)
	begin : g_reg
		logic [1:0] sel;
		logic norm, dly, ce, sclr, rst;
		assign sel = ctrl_q.clk_sel[2*g +: 2]; // R17
		assign ce = (~ctrl_q.ce_en[g/2] | i_cluster.clk_en[g/2]) &
			(ctrl_q.mode != MODE_ARITH | i_cluster.cnt_en); // R13 R14
		assign sclr = ctrl_q.sclr_en[g/2] & i_cluster.sclr[ctrl_q.sclr_sel[g/2]]; // R14
		assign rst = i_sys_rst |
			(ctrl_q.aclr_en[g/2] & i_cluster.aclr[ctrl_q.aclr_sel[g/2]]); // R14 R23
		always_comb
		begin
			unique case (ctrl_q.timing)
				TIMING_LATCH:
				begin
					norm = 1'b1; // R21 R22
					dly = dly_q[0]; // R21 R22
				end
				TIMING_BORROW:
				begin
					norm = i_cluster.cluster_clock[sel[0]]; // R19
					dly = dly_q[sel[0]]; // R19
				end
				default:
				begin
					norm = sel[1] ? dly_q[sel[0]] : i_cluster.cluster_clock[sel[0]]; // R17
					dly = norm;
				end
			endcase
		end
		element_register u_reg (
			.i_clk(i_clk),
			.i_rst(rst),
			.i_timing(ctrl_q.timing),
			.i_clk_norm(norm),
			.i_clk_dly(dly),
			.i_ce(ce),
			.i_sclr(sclr),
			.i_d(reg_data[g]),
			.o_q(o_reg[g])
		);
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	chk_wb_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("Bus ack held for more than one cycle.");

	chk_wb_ack_delay: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("Bus ack not given one cycle after request.");

	chk_cfg_static: assert property (i_run |=> (ctrl_q == $past(ctrl_q))) // R26
		else $error("Configuration changed while running.");

	chk_six_input: assert property ( // R1
		(ctrl_q.mode == MODE_NORMAL && ctrl_q.single6) |-> (o_comb[0] == mask_q[idx0[5]][idx0[4:0]]))
		else $error("Six-input function read the wrong entry.");

	chk_six_no_pack: assert property ( // R9
		(ctrl_q.mode == MODE_NORMAL && ctrl_q.single6) |-> (reg_data[1] == o_comb[0]))
		else $error("Packing active with a six-input function.");

	chk_pack_paths: assert property ( // R7
		(ctrl_q.mode == MODE_NORMAL && !ctrl_q.single6 && ctrl_q.pack == PACK_5LUT_2)
		|-> (reg_data[1] == i_data.shared_a && reg_data[3] == i_data.shared_b))
		else $error("Packed paths do not carry shared a and b.");

	chk_carry_sum: assert property ( // R15
		(ctrl_q.mode == MODE_ARITH) |-> ({o_carry_out, o_comb} ==
		{1'b0, t1_q0, t0_q0} + {1'b0, y1, y0} + {2'b00, cin}))
		else $error("Carry select disagrees with ripple sum.");

	chk_ext_select: assert property ( // R10
		(ctrl_q.mode == MODE_EXTENDED && t1_q0) |-> (o_comb[0] == t0_6))
		else $error("Extended mode picked the wrong table read.");

	cov_write: cover property (o_wb_ack && i_wb_we);
	cov_carry: cover property (ctrl_q.mode == MODE_ARITH && o_carry_out);
	cov_packed: cover property (pack_eff == PACK_3LUT_2 && o_reg[3]);

endmodule

/* File: verif/cluster_model.sv */
// Far side model: the cluster control block only; the bench drives the data inputs.
// Assumes the bench asks for clock pulses and sets cluster enables.
`timescale 1ns/1ps

module cluster_model
	import ale_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire cluster_ctrl_t i_ctl,
	output cluster_ctrl_t o_ctl
);
	// ---------------------------------------------------------------
	// Cluster clock source
	// ---------------------------------------------------------------
	logic clk_q; // Cluster clock 0 level, one pulse per request.
	logic clk_d; // Next level.

	// Clock 1 is held high, so after the first edge out of reset it never gives another.
	always_comb
	begin
		clk_d = i_tick;
		o_ctl = i_ctl;
		o_ctl.cluster_clock = {1'b1, clk_q};
	end

	// Registers the clock level on the system clock.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			clk_q <= 1'b0;
		else
			clk_q <= clk_d;
	end
endmodule

/* File: verif/adaptive_logic_element_bench.sv */
// Self-checking bench for the adaptive logic element.
// Assumes a classic Wishbone slave that acks one cycle after a request.
`timescale 1ns/1ps

module adaptive_logic_element_bench;
	import ale_pkg::*;
	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, cin = 1'b0, tick = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic ack, cout;
	logic [1:0] comb;
	logic [3:0] q;
	elem_in_t din = '0;
	cluster_ctrl_t uctl = '0, ctl;
	int err_total = 0;
	int comparisons = 0;

	always #20 i_clk = ~i_clk;

	cluster_model far (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(tick),
		.i_ctl(uctl), .o_ctl(ctl));
	adaptive_logic_element #(.ELEMENT_POS(0)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_run(run), .i_data(din),
		.i_cluster(ctl), .i_carry_in(cin), .o_carry_out(cout), .o_comb(comb), .o_reg(q));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// Holds the request until the rising edge that samples ack high,
	// takes read data there, and releases at that same edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] o);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
		do
		begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		o = rdat;
		if (n >= 50) chk("ack", 32'h1, 32'h0);
		cyc <= 1'b0; stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] o);
		wb(1'b0, a, 32'h0, 4'hF, o);
	endtask

	task automatic setin(input elem_in_t v);
		@(posedge i_clk);
		din <= v;
		@(negedge i_clk);
	endtask

	task automatic setctl(input cluster_ctrl_t v);
		@(posedge i_clk);
		uctl <= v;
		@(negedge i_clk);
	endtask

	// One cluster clock pulse, then the fixed capture latency passes.
	task automatic pulse();
		@(posedge i_clk);
		tick <= 1'b1;
		@(posedge i_clk);
		tick <= 1'b0;
		repeat (4) @(negedge i_clk);
	endtask

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd(CTRL_OFS, r); chk("ctrl", CTRL_RST, r);
		rd(MASK1_HI_OFS, r); chk("mask", MASK_RST, r);
		rd(STATUS_OFS, r); chk("status", 32'h0, r);
		rd(8'h40, r); chk("unmapped", 32'h0, r);
	endtask

	// Table 0 sees a, table 1 sees b; f only reaches a clear bit of table 1.
	task automatic t_split();
		wr(MASK0_LO_OFS, 32'h0000_0002);
		wr(MASK1_LO_OFS, 32'h0000_0004);
		setin(8'h81); chk("comb", 32'h1, comb);
		setin(8'h40); chk("comb", 32'h2, comb);
	endtask

	task automatic t_single6();
		wr(MASK0_HI_OFS, 32'h0000_0001);
		wr(CTRL_OFS, 32'h0000_0014);
		setin(8'h01); chk("comb", 32'h3, comb);
		rd(STATUS_OFS, r); chk("cfg_err", 32'h1, r[7]);
	endtask

	// Carry in is low first, so only the chain start can give the carry.
	task automatic t_arith();
		wr(CTRL_OFS, 32'h0000_0062);
		setin(8'h00); chk("carry", 32'h4, {cout, comb});
		setctl(10'h001); chk("down", 32'h0, {cout, comb});
		setctl(10'h000);
		wr(CTRL_OFS, 32'h0000_0022);
		cin <= 1'b1;
		@(negedge i_clk); chk("chain", 32'h4, {cout, comb});
		@(posedge i_clk);
		cin <= 1'b0;
		@(negedge i_clk); chk("chain", 32'h3, {cout, comb});
	endtask

	task automatic t_reg();
		wr(CTRL_OFS, 32'h0000_0000);
		wr(MASK0_LO_OFS, 32'hFFFF_FFFF);
		chk("reg", 32'h0, q);
		pulse(); chk("reg", 32'h3, q);
	endtask

	// Clear without enable must be ignored; with enable it wins.
	task automatic t_ce();
		wr(CTRL_OFS, 32'h000A_0000);
		setctl(10'h010); pulse(); chk("reg", 32'h3, q);
		setctl(10'h050); pulse(); chk("reg", 32'h0, q[1:0]);
		setctl(10'h000);
	endtask

	task automatic t_pack();
		wr(CTRL_OFS, 32'h0000_0004);
		pulse(); chk("packed", 32'h1, q[1:0]);
	endtask

	// Running drops writes; byte lanes merge into the old word.
	task automatic t_run();
		@(posedge i_clk);
		run <= 1'b1;
		wr(CTRL_OFS, 32'h0000_0001);
		rd(CTRL_OFS, r); chk("ctrl", 32'h4, r);
		run <= 1'b0;
		wb(1'b1, MASK1_LO_OFS, 32'hAABB_CCDD, 4'h2, r);
		rd(MASK1_LO_OFS, r); chk("lanes", 32'h0000_CC04, r);
	endtask

	// Table 1 bit 2 selects the six-input read of table 0; f flips it.
	task automatic t_ext();
		wr(CTRL_OFS, 32'h0000_0001);
		setin(8'h40); chk("ext", 32'h3, comb);
		setin(8'h41); chk("ext", 32'h2, comb);
		setin(8'h00); chk("ext", 32'h0, comb);
		wr(CTRL_OFS, 32'h0000_000D);
		rd(STATUS_OFS, r); chk("cfg_err", 32'h1, r[7]);
	endtask

	// The latch is open while the delayed clock is low and holds while high.
	task automatic t_latch();
		wr(CTRL_OFS, 32'h0000_0100);
		setin(8'h40);
		@(negedge i_clk); chk("latch", 32'hF, q);
		@(posedge i_clk);
		tick <= 1'b1;
		repeat (2) @(posedge i_clk);
		din <= 8'h00;
		repeat (2) @(negedge i_clk); chk("latch", 32'hF, q);
		@(posedge i_clk);
		tick <= 1'b0;
		repeat (4) @(negedge i_clk); chk("latch", 32'h3, q);
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_split();
		t_single6();
		t_arith();
		t_reg();
		t_ce();
		t_pack();
		t_run();
		t_ext();
		t_latch();
		stop_test();
	end

	// The whole run needs well under a thousand cycles.
	initial
	begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule
